// ==== verilog/salmc_pkg.sv ====
// Shared constants and types for the lock and mode control block
package salmc_pkg;

	// ********************
	// Register bus
	// ********************
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  STATUS_OFS   = 8'h04;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Control register fields, both detectors enabled after reset
	localparam int          CTRL_VID_EN_BIT = 0;
	localparam int          CTRL_ASI_EN_BIT = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h3;

	// Status register fields
	localparam int          ST_LOCK_BIT  = 0;
	localparam int          ST_MODE_LSB  = 1;
	localparam int          ST_AUTO_BIT  = 3;
	localparam int          ST_PLL_BIT   = 4;
	localparam int          ST_VALID_BIT = 5;

	// ********************
	// Word stream
	// ********************
	localparam int          WORD_BITS      = 10;
	localparam int          HIST_BITS      = 30;
	localparam logic [3:0]  LAST_PHASE     = 4'h9;
	localparam logic [3:0]  PCLK_HIGH_BITS = 4'h5;
	localparam logic [29:0] TRS_PATTERN    = 30'h3FF00000;
	localparam logic [9:0]  COMMA_NEG      = 10'h0FA;
	localparam logic [9:0]  COMMA_POS      = 10'h305;
	localparam int          ONES_MIN       = 4;
	localparam int          ONES_MAX       = 6;

	// ********************
	// Hysteresis counts
	// ********************
	localparam logic [5:0]  ASI_ENTER_LAST = 6'h1F;
	localparam logic [5:0]  ASI_LEAVE_LAST = 6'h1F;
	localparam logic [2:0]  TRS_MISS_LAST  = 3'h5;
	localparam logic [10:0] TRS_GAP_WORDS  = 11'h5A8;

	typedef enum logic [1:0]
	{
		MODE_SEARCH = 2'b00,
		MODE_VIDEO  = 2'b01,
		MODE_ASI    = 2'b10,
		MODE_THRU   = 2'b11
	} salmc_mode_t;

endpackage : salmc_pkg

// ==== verilog/salmc_sync2.sv ====
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none
module salmc_sync2
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end
		else
		begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule : salmc_sync2
`default_nettype wire

// ==== verilog/salmc_deser.sv ====
// Serial-to-parallel stage: bit history, word phase and word strobe
`timescale 1ns/100ps
`default_nettype none
module salmc_deser
	import salmc_pkg::*;
(
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// Bit stream
	input  wire logic                      serial_bit,
	input  wire logic                      realign,
	// Word side
	output logic      [salmc_pkg::HIST_BITS-1:0] hist,
	output logic                           word_stb,
	output logic      [3:0]                phase
);

	logic [HIST_BITS-1:0] hist_reg;
	logic [3:0]           phase_reg;

	assign hist     = hist_reg;
	assign phase    = phase_reg;
	// A realign closes the word at the current bit
	assign word_stb = realign | (phase_reg == LAST_PHASE);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hist_reg <= '0;
		else
			hist_reg <= {hist_reg[HIST_BITS-2:0], serial_bit};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase_reg <= '0;
		else if (word_stb)
			phase_reg <= '0;
		else
			phase_reg <= phase_reg + 4'h1;
	end

endmodule : salmc_deser
`default_nettype wire

// ==== verilog/salmc_lock_mode_ctrl.sv ====
// Lock detect and operating mode control with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module salmc_lock_mode_ctrl
	import salmc_pkg::*;
(
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address
	input  wire logic [salmc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [salmc_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [salmc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [salmc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Recovery stage, same clock
	input  wire logic                        serial_bit,
	input  wire logic                        recovery_pll_locked,
	input  wire logic                        input_signal_valid,
	// Mode pins
	input  wire logic                        auto_manual_select,
	input  wire logic                        video_format_pin_i,
	output logic                             video_format_pin_o,
	output logic                             video_format_pin_oe,
	input  wire logic                        transport_format_pin_i,
	output logic                             transport_format_pin_o,
	output logic                             transport_format_pin_oe,
	// Parallel outputs
	output logic                             lock_indicator,
	output logic      [salmc_pkg::WORD_BITS-1:0] data_out,
	output logic                             pclk_out
);

	// ********************
	// Pin synchronisers
	// ********************
	logic [2:0] pins_sync;
	logic       auto_sel;
	logic       fmt_video;
	logic       fmt_transport;

	salmc_sync2 #(.WIDTH(3)) u_pin_sync
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({auto_manual_select, video_format_pin_i,
		            transport_format_pin_i}),
		.sync_out (pins_sync)
	);

	assign auto_sel      = pins_sync[2];
	assign fmt_video     = pins_sync[1];
	assign fmt_transport = pins_sync[0];

	// ********************
	// Registers
	// ********************
	logic [1:0]  ctrl_reg;
	salmc_mode_t mode_reg;
	logic        vid_en;
	logic        asi_en;

	assign vid_en = ctrl_reg[CTRL_VID_EN_BIT];
	assign asi_en = ctrl_reg[CTRL_ASI_EN_BIT];

	// ********************
	// Search selection
	// ********************
	logic       link_ok;
	logic       search_video;
	logic       search_asi;
	logic       want_thru;
	logic       manual_ok;
	logic [1:0] app_drive_reg;

	// Pins count as application levels only once released long enough
	// for the synchronisers to flush the levels the block drove itself
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			app_drive_reg <= '0;
		else
			app_drive_reg <= {app_drive_reg[0], ~video_format_pin_oe};
	end

	assign manual_ok = ~auto_sel & app_drive_reg[1];

	assign link_ok = recovery_pll_locked & input_signal_valid;
	// Auto looks for both; manual only for what the pins select
	assign search_video = link_ok & vid_en & (auto_sel |
		(manual_ok & fmt_video & ~fmt_transport));
	assign search_asi = link_ok & asi_en &
		(auto_sel | (manual_ok & fmt_transport));
	assign want_thru = link_ok & manual_ok &
		~fmt_video & ~fmt_transport;

	// ********************
	// Deserialiser and aligners
	// ********************
	logic [HIST_BITS-1:0] hist;
	logic                 word_stb;
	logic [3:0]           phase;
	logic                 trs_hit;
	logic                 comma_hit;
	logic                 realign;
	logic [WORD_BITS-1:0] word;
	logic                 asi_word_ok;
	int                   ones;

	// Both aligners look at the same bit history
	assign trs_hit   = search_video & (hist == TRS_PATTERN);
	assign comma_hit = search_asi &
		((hist[WORD_BITS-1:0] == COMMA_NEG) |
		 (hist[WORD_BITS-1:0] == COMMA_POS));
	// Video owns alignment once locked to it
	assign realign = trs_hit | (comma_hit & (mode_reg != MODE_VIDEO));
	assign word    = hist[WORD_BITS-1:0];

	salmc_deser u_deser
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.serial_bit (serial_bit),
		.realign    (realign),
		.hist       (hist),
		.word_stb   (word_stb),
		.phase      (phase)
	);

	// Disparity-bounded words count as error-free transmission words
	always_comb
	begin
		ones        = $countones(word);
		asi_word_ok = (ones >= ONES_MIN) && (ones <= ONES_MAX);
	end

	// ********************
	// Hysteresis counters
	// ********************
	logic [5:0]  asi_good_cnt;
	logic [5:0]  asi_bad_cnt;
	logic [10:0] trs_gap_cnt;
	logic [2:0]  trs_miss_cnt;
	logic        gap_expired;

	assign gap_expired = (trs_gap_cnt == TRS_GAP_WORDS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !search_asi)
		begin
			asi_good_cnt <= '0;
			asi_bad_cnt  <= '0;
		end
		else if (word_stb)
		begin
			if (asi_word_ok)
			begin
				asi_bad_cnt <= '0;
				if (asi_good_cnt != ASI_ENTER_LAST)
					asi_good_cnt <= asi_good_cnt + 6'h1;
			end
			else
			begin
				asi_good_cnt <= '0;
				if (asi_bad_cnt != ASI_LEAVE_LAST)
					asi_bad_cnt <= asi_bad_cnt + 6'h1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode_reg != MODE_VIDEO)
		begin
			trs_gap_cnt  <= '0;
			trs_miss_cnt <= '0;
		end
		else if (word_stb)
		begin
			if (trs_hit)
			begin
				trs_gap_cnt  <= '0;
				trs_miss_cnt <= '0;
			end
			else if (gap_expired)
			begin
				trs_gap_cnt  <= '0;
				trs_miss_cnt <= trs_miss_cnt + 3'h1;
			end
			else
				trs_gap_cnt <= trs_gap_cnt + 11'h1;
		end
	end

	// ********************
	// Mode state machine
	// ********************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_reg <= MODE_SEARCH;
		else if (!link_ok)
			mode_reg <= MODE_SEARCH;
		else if (word_stb)
		begin
			case (mode_reg)
				MODE_SEARCH:
				begin
					if (want_thru)
						mode_reg <= MODE_THRU;
					else if (trs_hit)
						mode_reg <= MODE_VIDEO;
					else if (asi_word_ok &&
						asi_good_cnt == ASI_ENTER_LAST)
						mode_reg <= MODE_ASI;
				end
				MODE_VIDEO:
				begin
					if (!search_video)
						mode_reg <= MODE_SEARCH;
					else if (!trs_hit && gap_expired &&
						trs_miss_cnt == TRS_MISS_LAST)
						mode_reg <= MODE_SEARCH;
				end
				MODE_ASI:
				begin
					if (!search_asi)
						mode_reg <= MODE_SEARCH;
					else if (trs_hit)
						mode_reg <= MODE_VIDEO;
					else if (!asi_word_ok &&
						asi_bad_cnt == ASI_LEAVE_LAST)
						mode_reg <= MODE_SEARCH;
				end
				MODE_THRU:
				begin
					if (!want_thru)
						mode_reg <= MODE_SEARCH;
				end
				default:
					mode_reg <= MODE_SEARCH;
			endcase
		end
	end

	// ********************
	// Pin outputs
	// ********************
	logic locked;

	assign locked = link_ok & (mode_reg != MODE_SEARCH);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_indicator <= 1'b0;
		else
			lock_indicator <= locked;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !locked)
			data_out <= '0;
		else if (word_stb)
			data_out <= word;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			video_format_pin_o      <= 1'b0;
			transport_format_pin_o  <= 1'b0;
			video_format_pin_oe     <= 1'b0;
			transport_format_pin_oe <= 1'b0;
		end
		else
		begin
			video_format_pin_oe     <= auto_sel;
			transport_format_pin_oe <= auto_sel;
			video_format_pin_o      <= auto_sel & link_ok &
				(mode_reg == MODE_VIDEO);
			transport_format_pin_o  <= auto_sel & link_ok &
				(mode_reg == MODE_ASI);
		end
	end

	// Word-rate clock that runs in every mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pclk_out <= 1'b0;
		else
			pclk_out <= (phase < PCLK_HIGH_BITS);
	end

	// ********************
	// AXI4-Lite write
	// ********************
	logic                aw_have;
	logic                w_have;
	logic [ADDR_W-1:0]   aw_addr;
	logic [DATA_W-1:0]   w_data;
	logic [3:0]          w_strb;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (!aw_have && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (!w_have && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (aw_have && w_have)
			begin
				aw_have <= 1'b0;
				w_have  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			ctrl_reg     <= CTRL_RESET;
		end
		else if (aw_have && w_have)
		begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
			begin
				s_axi_bresp <= RESP_OKAY;
				if (w_strb[0])
					ctrl_reg <= w_data[1:0];
			end
			else if (aw_addr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ********************
	// AXI4-Lite read
	// ********************
	logic [DATA_W-1:0] status_word;

	always_comb
	begin
		status_word                  = '0;
		status_word[ST_LOCK_BIT]     = lock_indicator;
		status_word[ST_MODE_LSB+:2]  = mode_reg;
		status_word[ST_AUTO_BIT]     = auto_sel;
		status_word[ST_PLL_BIT]      = recovery_pll_locked;
		status_word[ST_VALID_BIT]    = input_signal_valid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= '0;
			if (s_axi_araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
				s_axi_rdata[1:0] <= ctrl_reg;
			else if (s_axi_araddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
				s_axi_rdata <= status_word;
			else
				s_axi_rresp <= RESP_SLVERR;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else
			s_axi_arready <= 1'b1;
	end

endmodule : salmc_lock_mode_ctrl
`default_nettype wire

// ==== test/salmc_source.sv ====
// Serial source model: junk, video timing words or transport commas
`timescale 1ns/100ps
`default_nettype none
module salmc_source
(
	// Clock
	input  wire logic       aclk,
	// Pattern: 0 junk, 1 video, 2 transport
	input  wire logic [1:0] kind,
	// Serial line
	output logic            serial_bit
);
	logic [3:0] bit_cnt;
	logic [1:0] word_cnt;
	logic [9:0] word;

	initial
	begin
		serial_bit = 1'b0;
		bit_cnt    = 4'h0;
		word_cnt   = 2'h0;
	end

	// Video repeats a timing sequence and one filler word
	always_comb
	begin
		word = 10'h000;
		if (kind == 2'h2)
			word = 10'h0FA;
		else if (kind == 2'h1 && word_cnt == 2'h0)
			word = 10'h3FF;
		else if (kind == 2'h1 && word_cnt == 2'h3)
			word = 10'h200;
	end

	// Ten-bit words, top bit sent first
	always @(posedge aclk)
	begin
		serial_bit <= word[4'h9 - bit_cnt];
		bit_cnt    <= (bit_cnt == 4'h9) ? 4'h0 : bit_cnt + 4'h1;
		if (bit_cnt == 4'h9)
			word_cnt <= word_cnt + 2'h1;
	end
endmodule : salmc_source
`default_nettype wire

// ==== test/salmc_checker.sv ====
// Port checker for the lock and mode control block
`timescale 1ns/100ps
`default_nettype none
module salmc_checker
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Register bus
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// Link and pins
	input wire logic       recovery_pll_locked,
	input wire logic       input_signal_valid,
	input wire logic       auto_manual_select,
	input wire logic       video_format_pin_o,
	input wire logic       video_format_pin_oe,
	input wire logic       transport_format_pin_o,
	input wire logic       transport_format_pin_oe,
	input wire logic       lock_indicator,
	input wire logic [9:0] data_out,
	input wire logic       pclk_out
);
	logic link;
	assign link = recovery_pll_locked && input_signal_valid;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	link_loss_clear_a:
	assert property (!link [*4] |-> !lock_indicator && data_out == 10'h000
		&& !video_format_pin_o && !transport_format_pin_o)
		else $error("outputs active without link");
	lock_needs_link_a:
	assert property ($rose(lock_indicator) |-> $past(link))
		else $error("lock rose without link");
	format_exclusive_a:
	assert property (!(video_format_pin_o && transport_format_pin_o))
		else $error("both formats reported");
	format_locked_a:
	assert property (video_format_pin_o || transport_format_pin_o
		|-> lock_indicator)
		else $error("format reported while unlocked");
	oe_pair_a:
	assert property (video_format_pin_oe == transport_format_pin_oe)
		else $error("format enables differ");
	oe_follows_mode_a:
	assert property ($stable(auto_manual_select) [*4]
		|=> video_format_pin_oe == $past(auto_manual_select))
		else $error("format enable not following mode");
	pclk_period_a:
	assert property ($rose(pclk_out) && lock_indicator
		|=> pclk_out [*4] ##1 !pclk_out [*5] ##1 pclk_out)
		else $error("parallel clock period wrong");
	data_cleared_a:
	assert property (!lock_indicator [*3] |-> data_out == 10'h000)
		else $error("data out while unlocked");
	read_answer_a:
	assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	one_write_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");

	video_lock_c: cover property (video_format_pin_o);
	asi_lock_c: cover property (transport_format_pin_o);
	thru_lock_c: cover property (lock_indicator && !video_format_pin_oe);
endmodule : salmc_checker

bind salmc_lock_mode_ctrl salmc_checker u_chk (.*);
`default_nettype wire

// ==== test/tb_sdi_asi_lock_mode_control.sv ====
// Self-checking bench for the lock and mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_sdi_asi_lock_mode_control;
	import salmc_pkg::*;

	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        recovery_pll_locked = 1'b0, input_signal_valid = 1'b0;
	logic        auto_manual_select = 1'b1, vid_app = 1'b0, tr_app = 1'b0;
	logic        video_format_pin_o, video_format_pin_oe, serial_bit;
	logic        transport_format_pin_o, transport_format_pin_oe;
	logic        lock_indicator, pclk_out;
	logic [9:0]  data_out;
	logic [1:0]  kind = 2'h0;
	logic [31:0] rd;
	int          failures = 0, n_compared = 0;
	wire         video_format_pin_i;
	wire         transport_format_pin_i;

	// Pin level: device drives when enabled, else application
	assign video_format_pin_i = video_format_pin_oe ? video_format_pin_o
		: vid_app;
	assign transport_format_pin_i = transport_format_pin_oe
		? transport_format_pin_o : tr_app;

	always #2 aclk = ~aclk;

	salmc_lock_mode_ctrl dut (.*);
	salmc_source u_src (.*);

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [31:0] probe(input int which);
		case (which)
			0: return 32'(lock_indicator);
			1: return 32'(video_format_pin_o);
			2: return 32'(data_out);
			3: return 32'({video_format_pin_o, transport_format_pin_o});
			default: return 32'({lock_indicator, video_format_pin_o,
				transport_format_pin_o, data_out});
		endcase
	endfunction : probe

	task automatic wait_for(input string what, input int which,
		input logic [31:0] val, input int limit);
		int i;
		i = 0;
		while (probe(which) !== val && i < limit)
		begin
			@(posedge aclk);
			i++;
		end
		check(what, val, probe(which));
	endtask : wait_for

	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
		logic aw_done;
		logic w_done;
		@(posedge aclk);
		s_axi_awaddr  <= addr;
		s_axi_wdata   <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			aw_done |= s_axi_awready;
			w_done |= s_axi_wready;
			if (aw_done)
				s_axi_awvalid <= 1'b0;
			if (w_done)
				s_axi_wvalid <= 1'b0;
		end
		do
			@(posedge aclk);
		while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] addr);
		@(posedge aclk);
		s_axi_araddr  <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
			@(posedge aclk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (!s_axi_rvalid);
		rd  = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic tally_and_finish;
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#200000;
		failures++;
		tally_and_finish();
	end

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_read(CTRL_OFS);
		check("ctrl reset", 32'(CTRL_RESET), rd);
		axi_write(CTRL_OFS, 32'h00000001);
		axi_read(CTRL_OFS);
		check("ctrl write", 32'h00000001, rd);
		axi_write(STATUS_OFS, 32'h0000003F);
		check("status write", 32'(RESP_OKAY), 32'(rsp));
		axi_write(8'h10, 32'h00000003);
		check("bad write", 32'(RESP_SLVERR), 32'(rsp));
		axi_read(8'h10);
		check("bad read", 32'(RESP_SLVERR), 32'(rsp));
		check("bad read data", 32'h00000000, rd);
		recovery_pll_locked <= 1'b1;
		input_signal_valid  <= 1'b1;
		kind <= 2'h2;
		repeat (600) @(posedge aclk);
		check("asi detect off", 32'h0, probe(0));
		axi_write(CTRL_OFS, 32'(CTRL_RESET));
		wait_for("asi lock", 0, 32'h1, 600);
		check("asi format", 32'h1, probe(3));
		axi_read(STATUS_OFS);
		check("status asi", 32'h0000003D, rd);
		kind <= 2'h0;
		repeat (280) @(posedge aclk);
		check("asi hold", 32'h1, probe(0));
		wait_for("asi leave", 0, 32'h0, 200);
		check("junk outputs", 32'h0, probe(4));
		kind <= 2'h2;
		repeat (250) @(posedge aclk);
		check("asi early", 32'h0, probe(0));
		wait_for("asi relock", 0, 32'h1, 200);
		kind <= 2'h1;
		wait_for("trs exit", 1, 32'h1, 100);
		check("video format", 32'h2, probe(3));
		recovery_pll_locked <= 1'b0;
		repeat (4) @(posedge aclk);
		check("pll loss", 32'h0, probe(4));
		recovery_pll_locked <= 1'b1;
		input_signal_valid  <= 1'b0;
		repeat (4) @(posedge aclk);
		check("carrier loss", 32'h0, probe(4));
		auto_manual_select <= 1'b0;
		vid_app <= 1'b1;
		kind <= 2'h2;
		input_signal_valid <= 1'b1;
		repeat (120)
		begin
			repeat (5) @(posedge aclk);
			check("manual settle", 32'h0, probe(0));
		end
		check("manual video", 32'h0, 32'({lock_indicator,
			video_format_pin_oe}));
		tr_app <= 1'b1;
		wait_for("manual asi", 0, 32'h1, 600);
		check("manual formats", 32'h0, probe(3));
		recovery_pll_locked <= 1'b0;
		vid_app <= 1'b0;
		tr_app <= 1'b0;
		repeat (4) @(posedge aclk);
		recovery_pll_locked <= 1'b1;
		wait_for("thru lock", 0, 32'h1, 100);
		wait_for("thru data", 2, 32'h000000FA, 100);
		tally_and_finish();
	end
endmodule : tb_sdi_asi_lock_mode_control
`default_nettype wire
